// [src/pml_lock_defs.vh]
// Constants for the programming-mode memory lock block.
// Assumes a byte-wide memory addressed as {page, offset within page}.
`ifndef PML_LOCK_DEFS_VH
`define PML_LOCK_DEFS_VH

// Slave address of the programming port (7 bits)
`define PML_SLAVE_ADDR 7'h50
// Lock byte location and value
`define PML_LOCK_PAGE 8'h30
`define PML_LOCK_OFFSET 7'h60
`define PML_LOCK_BLOCK 2'h3
`define PML_LOCK_VALUE 8'hff
`define PML_ERASE_VALUE 8'h00
// Command codes (values arbitrary)
`define PML_CMD_FULL_ERASE 8'h01
`define PML_CMD_SEQ_READ 8'h02
`define PML_CMD_STATUS 8'h03
`define PML_CMD_PAGE_SELECT 8'h04
`define PML_CMD_SINGLE_WRITE 8'h05
`define PML_CMD_BLOCK_WRITE 8'h06
`define PML_CMD_BLOCK_ADVANCE 8'h07
// Status error codes, low seven bits
`define PML_ERR_NONE 7'h00
`define PML_ERR_WRONG_CMD 7'h05
`define PML_ERR_NOT_ALLOWED 7'h06
// Pending read kinds
`define PML_RD_NONE 2'h0
`define PML_RD_SEQ 2'h1
`define PML_RD_STATUS 2'h2
// Bit counter values within a byte
`define PML_BIT_ACK 4'h8
`define PML_BIT_DONE 4'h9

`endif

// [src/pml_lock.v]
// Programming-mode I2C slave with memory read-out lock.
// Assumes an asynchronous memory: data stands on mem_rdata_in while mem_rd_out is high,
// a full erase is done by the memory on one mem_erase_out pulse.
`timescale 1ns/10ps
`include "pml_lock_defs.vh"

module pml_lock (
	// Clock and reset
	input wire ref_clk_in,
	input wire rst_in,
	// Programming mode level from pin
	input wire prog_mode_in,
	// I2C pins, SDA open drain
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe_n_out,
	// Memory port
	output reg [14:0] mem_addr_out,
	output reg mem_rd_out,
	input wire [7:0] mem_rdata_in,
	output reg mem_wr_out,
	output reg [7:0] mem_wdata_out,
	output reg mem_erase_out,
	// Lock state seen by the rest of the device
	output reg locked_out
);

	localparam PH_IDLE = 7'b0000001;
	localparam PH_ADDR = 7'b0000010;
	localparam PH_CMD = 7'b0000100;
	localparam PH_PAGE = 7'b0001000;
	localparam PH_OFF = 7'b0010000;
	localparam PH_WR = 7'b0100000;
	localparam PH_BLK = 7'b1000000;

	function in_id_block;
		input [14:0] a;
		begin
			in_id_block = (a[14:7] == `PML_LOCK_PAGE) && (a[6:5] == `PML_LOCK_BLOCK);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detection

	reg scl_s1_q, scl_s2_q, scl_s3_q;
	reg sda_s1_q, sda_s2_q, sda_s3_q;
	reg mode_s1_q, mode_s2_q, mode_s3_q;

	always @(posedge ref_clk_in) begin
		if (rst_in) begin
			{scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
			{sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
			{mode_s1_q, mode_s2_q, mode_s3_q} <= 3'h0;
		end else begin
			{scl_s1_q, scl_s2_q, scl_s3_q} <= {scl_in, scl_s1_q, scl_s2_q};
			{sda_s1_q, sda_s2_q, sda_s3_q} <= {sda_in, sda_s1_q, sda_s2_q};
			{mode_s1_q, mode_s2_q, mode_s3_q} <= {prog_mode_in, mode_s1_q, mode_s2_q};
		end
	end

	wire scl_rise = scl_s2_q && !scl_s3_q;
	wire scl_fall = !scl_s2_q && scl_s3_q;
	wire start_cond = scl_s2_q && scl_s3_q && !sda_s2_q && sda_s3_q;
	wire stop_cond = scl_s2_q && scl_s3_q && sda_s2_q && !sda_s3_q;
	wire mode_on = mode_s2_q && !mode_s3_q;
	wire mode_off = !mode_s2_q && mode_s3_q;

	////////////////////////////////////////////////////////////////////////////
	// Byte engine and command handling

	reg [6:0] phase_q;
	reg [3:0] bit_q;
	reg [7:0] rx_q;
	reg [7:0] tx_q;
	reg tx_mode_q;
	reg [1:0] rd_kind_q;
	reg err_pend_q;
	reg [6:0] err_code_q;
	reg [7:0] page_q;
	reg [6:0] off_q;
	reg [4:0] blk_idx_q;
	reg lock_fetch_q;
	reg tx_fetch_q;
	wire [7:0] rx_byte = rx_q;
	wire [14:0] blk_addr = {page_q, off_q[6:5], blk_idx_q};
	wire cmd_allowed_locked = (rx_byte == `PML_CMD_FULL_ERASE) ||
		(rx_byte == `PML_CMD_SEQ_READ) || (rx_byte == `PML_CMD_STATUS);

	always @(posedge ref_clk_in) begin
		if (rst_in) begin
			phase_q <= PH_IDLE;
			bit_q <= 4'h0;
			rx_q <= 8'h00;
			tx_q <= 8'h00;
			tx_mode_q <= 1'b0;
			rd_kind_q <= `PML_RD_NONE;
			err_pend_q <= 1'b0;
			err_code_q <= `PML_ERR_NONE;
			page_q <= 8'h00;
			off_q <= 7'h00;
			blk_idx_q <= 5'h00;
			lock_fetch_q <= 1'b0;
			tx_fetch_q <= 1'b0;
			locked_out <= 1'b0;
			sda_out <= 1'b0;
			sda_oe_n_out <= 1'b1;
			mem_addr_out <= 15'h0000;
			mem_rd_out <= 1'b0;
			mem_wr_out <= 1'b0;
			mem_wdata_out <= 8'h00;
			mem_erase_out <= 1'b0;
		end else begin
			mem_rd_out <= 1'b0;
			mem_wr_out <= 1'b0;
			mem_erase_out <= 1'b0;
			lock_fetch_q <= 1'b0;
			tx_fetch_q <= 1'b0;
			if (lock_fetch_q) begin
				locked_out <= (mem_rdata_in == `PML_LOCK_VALUE);
			end
			if (tx_fetch_q) begin
				tx_q <= mem_rdata_in;
			end
			if (mode_on) begin
				mem_addr_out <= {`PML_LOCK_PAGE, `PML_LOCK_OFFSET};
				mem_rd_out <= 1'b1;
				lock_fetch_q <= 1'b1;
				err_code_q <= `PML_ERR_NONE;
				page_q <= 8'h00;
				off_q <= 7'h00;
			end else if (mode_off) begin
				locked_out <= 1'b0;
				phase_q <= PH_IDLE;
				tx_mode_q <= 1'b0;
				sda_oe_n_out <= 1'b1;
			end else if (!mode_s2_q) begin
				sda_oe_n_out <= 1'b1;
			end else if (start_cond) begin
				phase_q <= PH_ADDR;
				bit_q <= 4'h0;
				tx_mode_q <= 1'b0;
				sda_oe_n_out <= 1'b1;
			end else if (stop_cond) begin
				phase_q <= PH_IDLE;
				tx_mode_q <= 1'b0;
				err_pend_q <= 1'b0;
				sda_oe_n_out <= 1'b1;
			end else if (scl_rise && !phase_q[0]) begin
				if (bit_q < `PML_BIT_ACK) begin
					rx_q <= {rx_q[6:0], sda_s2_q};
				end else if (tx_mode_q) begin
					// Only sequential reads refetch; a status byte must not be overwritten
					if (sda_s2_q || (rd_kind_q == `PML_RD_SEQ) && locked_out &&
						!in_id_block({page_q, off_q})) begin
						tx_mode_q <= 1'b0;
						phase_q <= PH_IDLE;
						if (!sda_s2_q) begin
							err_code_q <= `PML_ERR_NOT_ALLOWED;
						end
					end else if (rd_kind_q == `PML_RD_SEQ) begin
						mem_addr_out <= {page_q, off_q};
						mem_rd_out <= 1'b1;
						tx_fetch_q <= 1'b1;
					end
				end
				bit_q <= bit_q + 4'h1;
			end else if (scl_fall && !phase_q[0]) begin
				if (bit_q == `PML_BIT_ACK && tx_mode_q) begin
					sda_oe_n_out <= 1'b1;
				end else if (bit_q == `PML_BIT_ACK) begin
					sda_oe_n_out <= 1'b0;
					case (phase_q)
					PH_ADDR: begin
						if (rx_byte[7:1] != `PML_SLAVE_ADDR) begin
							sda_oe_n_out <= 1'b1;
							phase_q <= PH_IDLE;
						end else if (!rx_byte[0]) begin
							phase_q <= PH_CMD;
						end else if (rd_kind_q == `PML_RD_STATUS) begin
							tx_q <= {locked_out, err_code_q};
							tx_mode_q <= 1'b1;
							rd_kind_q <= `PML_RD_NONE;
						end else if (rd_kind_q == `PML_RD_SEQ &&
							(!locked_out || in_id_block({page_q, off_q}))) begin
							mem_addr_out <= {page_q, off_q};
							mem_rd_out <= 1'b1;
							tx_fetch_q <= 1'b1;
							tx_mode_q <= 1'b1;
						end else begin
							sda_oe_n_out <= 1'b1;
							err_code_q <= `PML_ERR_NOT_ALLOWED;
							phase_q <= PH_IDLE;
						end
					end
					PH_CMD: begin
						if (err_pend_q) begin
							sda_oe_n_out <= 1'b1;
							phase_q <= PH_IDLE;
						end else if (locked_out && !cmd_allowed_locked) begin
							err_code_q <= `PML_ERR_NOT_ALLOWED;
							err_pend_q <= 1'b1;
						end else begin
							case (rx_byte)
							`PML_CMD_FULL_ERASE: begin
								mem_erase_out <= 1'b1;
								locked_out <= 1'b0;
							end
							`PML_CMD_SEQ_READ: rd_kind_q <= `PML_RD_SEQ;
							`PML_CMD_STATUS: rd_kind_q <= `PML_RD_STATUS;
							`PML_CMD_PAGE_SELECT: phase_q <= PH_PAGE;
							`PML_CMD_SINGLE_WRITE: phase_q <= PH_OFF;
							`PML_CMD_BLOCK_WRITE: begin
								blk_idx_q <= 5'h00;
								phase_q <= PH_BLK;
							end
							`PML_CMD_BLOCK_ADVANCE: begin
								off_q <= {off_q[6:5] + 2'h1, 5'h00};
								if (off_q[6:5] == 2'h3) begin
									page_q <= page_q + 8'h01;
								end
							end
							default: begin
								err_code_q <= `PML_ERR_WRONG_CMD;
								err_pend_q <= 1'b1;
							end
							endcase
						end
					end
					PH_PAGE: begin
						page_q <= rx_byte;
						off_q <= 7'h00;
						phase_q <= PH_CMD;
					end
					PH_OFF: begin
						off_q <= rx_byte[6:0];
						phase_q <= PH_WR;
					end
					PH_WR: begin
						// A lock byte write takes effect at the next mode entry
						mem_addr_out <= {page_q, off_q};
						mem_wdata_out <= rx_byte;
						mem_wr_out <= !locked_out;
						phase_q <= PH_CMD;
					end
					PH_BLK: begin
						mem_addr_out <= blk_addr;
						mem_wdata_out <= rx_byte;
						mem_wr_out <= !locked_out;
						blk_idx_q <= blk_idx_q + 5'h01;
						if (blk_idx_q == 5'h1f) begin
							phase_q <= PH_CMD;
						end
					end
					default: phase_q <= PH_IDLE;
					endcase
				end else if (bit_q == `PML_BIT_DONE) begin
					bit_q <= 4'h0;
					sda_oe_n_out <= tx_mode_q ? tx_q[7] : 1'b1;
					if (tx_mode_q) begin
						tx_q <= {tx_q[6:0], 1'b0};
						if (rd_kind_q == `PML_RD_SEQ) begin
							off_q <= off_q + 7'h01;
						end
					end
				end else if (tx_mode_q) begin
					sda_oe_n_out <= tx_q[7];
					tx_q <= {tx_q[6:0], 1'b0};
				end
			end
		end
	end

endmodule // pml_lock

// [test/pml_lock_asserts.sv]
// Port checker for the memory lock block.
// Bound to pml_lock below; sees its ports only.
`timescale 1ns/10ps
module pml_lock_asserts (
	// Clock and pins
	input wire ref_clk_in,
	input wire rst_in,
	input wire prog_mode_in,
	input wire scl_in,
	input wire sda_oe_n_out,
	// Memory and lock
	input wire [14:0] mem_addr_out,
	input wire mem_rd_out,
	input wire [7:0] mem_rdata_in,
	input wire mem_wr_out,
	input wire mem_erase_out,
	input wire locked_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	property p_val; $rose(locked_out) |-> $past(mem_rdata_in) == 8'hff; endproperty
	a_val: assert property (p_val) else $error("lock without ff");
	property p_adr; $rose(locked_out) |-> mem_addr_out == 15'h1860; endproperty
	a_adr: assert property (p_adr) else $error("lock from wrong byte");
	property p_entry; $rose(locked_out) |-> !$past(prog_mode_in, 8); endproperty
	a_entry: assert property (p_entry) else $error("lock mid session");
	property p_hold; locked_out && prog_mode_in |=> locked_out || mem_erase_out; endproperty
	a_hold: assert property (p_hold) else $error("lock dropped");
	property p_erase; mem_erase_out |-> ##[0:2] !locked_out; endproperty
	a_erase: assert property (p_erase) else $error("erase kept lock");
	property p_no_wr; locked_out |-> !mem_wr_out; endproperty
	a_no_wr: assert property (p_no_wr) else $error("write while locked");
	property p_blk; locked_out && mem_rd_out |-> mem_addr_out[14:5] == 10'h0c3; endproperty
	a_blk: assert property (p_blk) else $error("read outside block");
	property p_wr; mem_wr_out && !locked_out |=> !locked_out [*8]; endproperty
	a_wr: assert property (p_wr) else $error("write locked now");
	property p_ack; $changed(sda_oe_n_out) |-> !scl_in; endproperty
	a_ack: assert property (p_ack) else $error("sda moved, scl high");
	c_lock: cover property ($rose(locked_out));
	c_erase: cover property (mem_erase_out && locked_out);
	c_wr: cover property (mem_wr_out);
endmodule // pml_lock_asserts
bind pml_lock pml_lock_asserts chk (.*);

// [test/pml_prog_model.sv]
// Programmer model: I2C master, 80 ns bit time, open-drain SDA.
// Assumes sda_in is the resolved wire with pull-up; SCL stands high between frames.
`timescale 1ns/10ps
module pml_prog_model (
	// I2C side
	output reg scl_out,
	output reg sda_oe_n_out,
	input wire sda_in
);
	initial scl_out = 1'b1;
	initial sda_oe_n_out = 1'b1;
	// Data set mid low phase, sampled mid high phase
	task bit_x(input b, output r);
		#20 sda_oe_n_out = b;
		#20 scl_out = 1'b1;
		#20 r = sda_in;
		#20 scl_out = 1'b0;
	endtask
	task start;
		#20 sda_oe_n_out = 1'b0;
		#20 scl_out = 1'b0;
	endtask
	// Each frame ends with a stop so the next one restarts
	task stop;
		#20 sda_oe_n_out = 1'b0;
		#20 scl_out = 1'b1;
		#20 sda_oe_n_out = 1'b1;
		#20;
	endtask
	task wr_byte(input [7:0] v, output ack);
		integer i;
		reg r;
		for (i = 7; i >= 0; i--) bit_x(v[i], r);
		bit_x(1'b1, r);
		ack = !r;
	endtask
	task rd_byte(input last, output [7:0] v);
		integer i;
		reg r;
		for (i = 7; i >= 0; i--) bit_x(1'b1, v[i]);
		bit_x(last, r);
	endtask
endmodule // pml_prog_model

// [test/test_pml_lock.sv]
// Bench for the memory lock block with a byte memory and random data.
// Assumes the checker is bound to uut.
`timescale 1ns/10ps
module test_pml_lock;
	reg ref_clk_in = 1'b0;
	reg rst_in = 1'b1;
	reg prog_mode_in = 1'b0;
	reg [7:0] mem [0:32767];
	reg [7:0] pg, dt, c, d, e;
	integer k, fails = 0, tests_run = 0;
	wire scl_in, m_oe_n, sda_out, sda_oe_n_out, mem_rd_out, mem_wr_out, mem_erase_out, locked_out;
	wire [14:0] mem_addr_out;
	wire [7:0] mem_wdata_out;
	// Read data stands while the read strobe is high; garbage otherwise
	wire [7:0] mem_rdata_in = mem_rd_out ? mem[mem_addr_out] : ~mem[mem_addr_out];
	wire sda_in = (sda_oe_n_out ? 1'b1 : sda_out) & m_oe_n;
	pml_lock uut (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.prog_mode_in(prog_mode_in),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_out(sda_out),
		.sda_oe_n_out(sda_oe_n_out),
		.mem_addr_out(mem_addr_out),
		.mem_rd_out(mem_rd_out),
		.mem_rdata_in(mem_rdata_in),
		.mem_wr_out(mem_wr_out),
		.mem_wdata_out(mem_wdata_out),
		.mem_erase_out(mem_erase_out),
		.locked_out(locked_out)
	);
	pml_prog_model m (.scl_out(scl_in), .sda_oe_n_out(m_oe_n), .sda_in(sda_in));
	initial forever #4 ref_clk_in = ~ref_clk_in;
	always @(posedge ref_clk_in) begin
		if (mem_wr_out) mem[mem_addr_out] <= mem_wdata_out;
		if (mem_erase_out) for (k = 0; k < 32768; k++) mem[k] <= 8'h00;
	end
	function [7:0] stat(input l, input [6:0] code);
		stat = {l, code};
	endfunction
	task chk(input string n, input [7:0] ex, input [7:0] got);
		tests_run++;
		if (got !== ex) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, ex, got);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task wb(input [7:0] b, input ex);
		reg a;
		m.wr_byte(b, a);
		chk("ack", {7'h0, ex}, {7'h0, a});
	endtask
	task cmd(input [7:0] cc);
		m.start;
		wb(8'ha0, 1'b1);
		wb(cc, 1'b1);
	endtask
	task put(input [7:0] o, input [7:0] v);
		wb(8'h05, 1'b1);
		wb(o, 1'b1);
		wb(v, 1'b1);
	endtask
	task fetch(output [7:0] v);
		m.stop;
		m.start;
		wb(8'ha1, 1'b1);
		m.rd_byte(1'b1, v);
		m.stop;
	endtask
	task status(input [7:0] ex);
		cmd(8'h03);
		fetch(d);
		chk("status", ex, d);
	endtask
	task mode(input v);
		@(negedge ref_clk_in) prog_mode_in = v;
		repeat (12) @(negedge ref_clk_in);
		#3;
	endtask
	task lk(input ex);
		chk("locked", {7'h0, ex}, {7'h0, locked_out});
	endtask
	initial #400000 begin
		fails++;
		stop_test;
	end
	initial begin
		d = $urandom(32'hf3e34094);
		for (k = 0; k < 32768; k++) mem[k] = $urandom;
		mem[15'h1860] = 8'hfe;
		repeat (20) @(negedge ref_clk_in);
		rst_in = 1'b0;
		mode(1'b1);
		lk(1'b0);
		status(stat(1'b0, 7'h00));
		pg = $urandom_range(47);
		e = $urandom_range(127);
		dt = $urandom;
		cmd(8'h04);
		wb(pg, 1'b1);
		put(e, dt);
		m.stop;
		chk("wdata", dt, mem[{pg, e[6:0]}]);
		cmd(8'h04);
		wb(8'h30, 1'b1);
		put(8'h60, 8'hff);
		put(8'h61, dt);
		m.stop;
		lk(1'b0);
		e = mem[{pg, 7'h00}];
		cmd(8'h04);
		wb(pg, 1'b1);
		wb(8'h02, 1'b1);
		fetch(d);
		chk("rdata", e, d);
		cmd($urandom_range(255, 8));
		wb(dt, 1'b0);
		m.stop;
		status(stat(1'b0, 7'h05));
		mode(1'b0);
		mode(1'b1);
		lk(1'b1);
		status(stat(1'b1, 7'h00));
		for (c = 8'h04; c < 8'h08; c++) begin
			cmd(c);
			wb(dt, 1'b0);
			m.stop;
			status(stat(1'b1, 7'h06));
		end
		cmd(8'h02);
		m.stop;
		m.start;
		wb(8'ha1, 1'b0);
		m.stop;
		status(stat(1'b1, 7'h06));
		cmd(8'h01);
		m.stop;
		#80;
		lk(1'b0);
		mode(1'b0);
		mode(1'b1);
		lk(1'b0);
		stop_test;
	end
endmodule // test_pml_lock
